// ---- rls_pkg.sv ----
/*
 * Shared constants for the radio link supervisor: register map, field
 * positions, reset values, timing counts and state encodings.
 * Assumes a single 100 MHz system clock and a 32-bit classic Wishbone bus.
 */
`default_nettype none

package rls_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SEC_NS = 1000000000;
	localparam int SEC_CYC = SEC_NS / CLK_PERIOD_NS;
	localparam int IVL_MIN = 15;
	localparam int IVL_SEC = IVL_MIN * 60;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PWR_MAX = 8'h04;
	localparam logic [7:0] A_CAP_LVL = 8'h08;
	localparam logic [7:0] A_CAP_TMO = 8'h0c;
	localparam logic [7:0] A_FREQ = 8'h10;
	localparam logic [7:0] A_SCRIPT = 8'h14;
	localparam logic [7:0] A_THR0 = 8'h18;
	localparam logic [7:0] A_THR1 = 8'h1c;
	localparam logic [7:0] A_THR2 = 8'h20;
	localparam logic [7:0] A_BER = 8'h24;
	localparam logic [7:0] A_RSL_ALM = 8'h28;
	localparam logic [7:0] A_STATUS = 8'h2c;
	localparam logic [7:0] A_TXLVL = 8'h30;
	localparam logic [7:0] A_RES_SEL = 8'h34;
	localparam logic [7:0] A_RES_MM = 8'h38;
	localparam logic [7:0] A_RES_AVG = 8'h3c;
	localparam logic [7:0] A_RES_CNT = 8'h40;
	// ==========================================================
	// Field positions
	localparam int CTRL_CAP_EN = 0;
	localparam int CTRL_CANCEL = 1;
	localparam int SCR_CROSS_POLAR_CANCELLER_OK = 16;
	localparam int SCR_HSB = 17;
	localparam int ST_SINGLE = 0;
	localparam int ST_XOK = 1;
	localparam int ST_XALM = 2;
	localparam int ST_COND = 3;
	localparam int ST_TIMING = 7;
	localparam int ST_CAPPED = 8;
	localparam int ST_BER_EXC = 9;
	localparam int ST_BER_DEG = 10;
	localparam int ST_RSL = 11;
	localparam int ST_CARRIER = 12;
	localparam int P_UP = 2;
	localparam int P_DN = 3;
	localparam int P_PEER = 4;
	localparam int P_SW = 5;
	localparam int NPIN = 6;
	// Carriers reset as in service, so leaving reset is not taken for a drop.
	localparam logic [NPIN-1:0] PIN_RST = 6'h03;
	// ==========================================================
	// Reset values and fixed levels
	localparam logic signed [7:0] R_PWR_MAX = 8'h14;
	localparam logic signed [7:0] R_CAP_LVL = 8'h0a;
	localparam logic [15:0] R_CAP_TMO = 16'h003c;
	localparam logic signed [7:0] PWR_FLOOR = 8'hf6;
	localparam logic [6:0] UTIL_MAX = 7'h64;
	localparam logic [15:0] THR_ZERO = 16'h0000;
	localparam logic [15:0] THR_NONE = 16'hffff;
	localparam logic [15:0] STAT_MIN_INIT = 16'hffff;
	localparam logic [15:0] STAT_MAX_INIT = 16'h0000;
	localparam int SUM_W = 26;
	// ==========================================================
	// Statistics channels: radio r measure m sits at r*4+m
	localparam int NCH = 12;
	localparam int CH_UTIL = 8;
	localparam int CH_THRU = 9;
	localparam int CH_CAPY = 10;
	localparam int CH_FER = 11;
	// ==========================================================
	// States
	typedef enum logic {XPC_DUAL = 1'b0, XPC_SINGLE = 1'b1} rls_xpc_t;
	typedef enum logic [1:0] {
		CAP_NORMAL = 2'b00,
		CAP_TIMING = 2'b01,
		CAP_ACTIVE = 2'b10
	} rls_cap_t;
endpackage : rls_pkg

`default_nettype wire

// ---- rls_stat.sv ----
/*
 * One statistics channel: min, max, average and two out-of-threshold
 * second counts over an interval, latched at each interval boundary.
 * Assumes the second strobe precedes the interval strobe by one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module rls_stat
	import rls_pkg::*;
#(
	parameter int IVL_S = IVL_SEC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Strobes
	input wire logic sec_tick_i,
	input wire logic ivl_tick_i,
	// Sample and thresholds
	input wire logic [15:0] val_i,
	input wire logic [15:0] thr_a_i,
	input wire logic [15:0] thr_b_i,
	input wire logic b_below_i,
	// Latched results
	output logic [15:0] min_o,
	output logic [15:0] max_o,
	output logic [15:0] avg_o,
	output logic [15:0] cnt_a_o,
	output logic [15:0] cnt_b_o
);
	logic [15:0] min_acc;
	logic [15:0] max_acc;
	logic [SUM_W-1:0] sum_acc;
	logic [15:0] cnt_a;
	logic [15:0] cnt_b;
	logic out_b;

	assign out_b = b_below_i ? (val_i < thr_b_i) : (val_i > thr_b_i);

	// ==========================================================
	// Accumulation, one sample per second
	// seconds out of threshold
	always_ff @(posedge clk_i) begin
		if (rst_i || ivl_tick_i) begin
			min_acc <= STAT_MIN_INIT;
			max_acc <= STAT_MAX_INIT;
			sum_acc <= '0;
			cnt_a <= '0;
			cnt_b <= '0;
		end else if (sec_tick_i) begin
			if (val_i < min_acc) begin
				min_acc <= val_i;
			end
			if (val_i > max_acc) begin
				max_acc <= val_i;
			end
			sum_acc <= sum_acc + SUM_W'(val_i);
			cnt_a <= cnt_a + 16'(val_i < thr_a_i);
			cnt_b <= cnt_b + 16'(out_b);
		end
	end

	// ==========================================================
	// Interval latch
	// latch then clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			min_o <= '0;
			max_o <= '0;
			avg_o <= '0;
			cnt_a_o <= '0;
			cnt_b_o <= '0;
		end else if (ivl_tick_i) begin
			min_o <= min_acc;
			max_o <= max_acc;
			avg_o <= 16'(sum_acc / SUM_W'(IVL_S));
			cnt_a_o <= cnt_a;
			cnt_b_o <= cnt_b;
		end
	end
endmodule : rls_stat

`default_nettype wire

// ---- rls_top.sv ----
/*
 * Radio link supervisor: dual-carrier cross-polar recovery and checks,
 * closed-loop transmit power with a power cap timer, and per-interval
 * performance measures, all behind a classic Wishbone slave.
 * Assumes carrier, link and peer pins are asynchronous; measurement
 * inputs come from logic on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module rls_top
	import rls_pkg::*;
#(
	parameter int TICKS_PER_S = SEC_CYC,
	parameter int IVL_S = IVL_SEC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Carrier and link pins
	input wire logic [1:0] carrier_up_i,
	input wire logic far_pwr_up_i,
	input wire logic far_pwr_dn_i,
	input wire logic peer_cap_i,
	input wire logic switchover_i,
	// Measurements
	input wire logic [7:0][15:0] sq_i,
	input wire logic [6:0] util_i,
	input wire logic [15:0] thru_i,
	input wire logic [15:0] capy_i,
	input wire logic [15:0] fer_i,
	input wire logic [15:0] ber_i,
	// Link and alarm outputs
	output logic [1:0] mute_req_o,
	output logic single_carrier_o,
	output logic cross_polar_canceller_ok_o,
	output logic xpc_alarm_o,
	output logic [3:0] xpc_cond_evt_o,
	output logic signed [7:0] tx_level_o,
	output logic cap_alarm_o,
	output logic ber_exc_alarm_o,
	output logic ber_deg_alarm_o,
	output logic rsl_alarm_o,
	output logic ivl_done_o
);
	// ==========================================================
	// Declarations
	logic [NPIN-1:0] pin_m;
	logic [NPIN-1:0] pin_s;
	logic [NPIN-1:0] pin_q;
	logic up_evt;
	logic dn_evt;
	logic sw_evt;
	logic both_up;
	rls_xpc_t xpc_st;
	rls_cap_t cap_st;
	logic [3:0] cond;
	logic [3:0] cond_q;
	logic cap_en;
	logic cap_cancel;
	logic signed [7:0] pwr_max;
	logic signed [7:0] cap_lvl;
	logic signed [7:0] limit;
	logic [15:0] cap_tmo;
	logic [15:0] tmo_cnt;
	logic [15:0] next_tmo;
	logic [15:0] freq0;
	logic [15:0] freq1;
	logic [7:0] script0;
	logic [7:0] script1;
	logic script_xok;
	logic hsb_en;
	logic [15:0] rsl_thr1;
	logic [15:0] rsl_thr2;
	logic [15:0] tsl_hi;
	logic [15:0] mse_hi;
	logic [15:0] xpi_lo;
	logic [6:0] util_thr;
	logic [15:0] ber_exc_thr;
	logic [15:0] ber_deg_thr;
	logic [15:0] rsl_alm_thr;
	logic [3:0] res_sel;
	logic [26:0] sec_div;
	logic [9:0] ivl_cnt;
	logic sec_tick;
	logic wb_req;
	logic wb_wr;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic [31:0] status;
	logic [15:0] ch_val [NCH];
	logic [15:0] ch_ta [NCH];
	logic [15:0] ch_tb [NCH];
	logic ch_bb [NCH];
	logic [15:0] r_min [NCH];
	logic [15:0] r_max [NCH];
	logic [15:0] r_avg [NCH];
	logic [15:0] r_ca [NCH];
	logic [15:0] r_cb [NCH];

	// Byte lanes not selected keep the register's present contents.
	function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction : bmerge

	// ==========================================================
	// Pin synchronisers and edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_m <= PIN_RST;
			pin_s <= PIN_RST;
			pin_q <= PIN_RST;
		end else begin
			pin_m <= {switchover_i, peer_cap_i, far_pwr_dn_i, far_pwr_up_i, carrier_up_i};
			pin_s <= pin_m;
			pin_q <= pin_s;
		end
	end
	assign up_evt = pin_s[P_UP] & ~pin_q[P_UP];
	assign dn_evt = pin_s[P_DN] & ~pin_q[P_DN];
	assign sw_evt = pin_s[P_SW] & ~pin_q[P_SW];
	assign both_up = &pin_s[1:0];

	// ==========================================================
	// Cross-polar recovery, which has no disable by design
	// always armed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xpc_st <= XPC_DUAL;
		end else begin
			case (xpc_st)
				XPC_DUAL: xpc_st <= both_up ? XPC_DUAL : XPC_SINGLE;
				XPC_SINGLE: xpc_st <= both_up ? XPC_DUAL : XPC_SINGLE;
				default: xpc_st <= XPC_DUAL;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mute_req_o <= '0;
		end else begin
			mute_req_o <= (xpc_st == XPC_SINGLE) ? ~pin_s[1:0] : 2'b00;
		end
	end
	assign single_carrier_o = (xpc_st == XPC_SINGLE);

	assign cond = {script_xok, script0 == script1, ~hsb_en, freq0 == freq1};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cond_q <= 4'hf;
			xpc_alarm_o <= 1'b0;
			xpc_cond_evt_o <= '0;
			cross_polar_canceller_ok_o <= 1'b0;
		end else begin
			cond_q <= cond;
			xpc_alarm_o <= ~&cond;
			xpc_cond_evt_o <= cond_q & ~cond;
			cross_polar_canceller_ok_o <= (&cond) && (xpc_st == XPC_DUAL);
		end
	end

	// ==========================================================
	// Closed-loop transmit power
	assign limit = (cap_st == CAP_ACTIVE) ? cap_lvl : pwr_max;

	// follow far end / stop at maximum / cap level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_level_o <= PWR_FLOOR;
		end else if (tx_level_o > limit) begin
			tx_level_o <= limit;
		end else if (up_evt && !dn_evt && tx_level_o < limit) begin
			tx_level_o <= tx_level_o + 8'sh01;
		end else if (dn_evt && !up_evt && tx_level_o > PWR_FLOOR) begin
			tx_level_o <= tx_level_o - 8'sh01;
		end
	end

	assign next_tmo = tmo_cnt + 16'h0001;

	// timer start / abort / hold / take over
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_st <= CAP_NORMAL;
			tmo_cnt <= '0;
		end else if (sw_evt && pin_s[P_PEER]) begin
			cap_st <= CAP_ACTIVE;
		end else begin
			case (cap_st)
				CAP_NORMAL: begin
					tmo_cnt <= '0;
					if (cap_en && tx_level_o == pwr_max) begin
						cap_st <= CAP_TIMING;
					end
				end
				CAP_TIMING: begin
					if (!cap_en || tx_level_o < pwr_max) begin
						cap_st <= CAP_NORMAL;
						tmo_cnt <= '0;
					end else if (sec_tick) begin
						if (next_tmo >= cap_tmo) begin
							cap_st <= CAP_ACTIVE;
						end
						tmo_cnt <= next_tmo;
					end
				end
				CAP_ACTIVE: begin
					if (cap_cancel) begin
						cap_st <= CAP_NORMAL;
					end
				end
				default: cap_st <= CAP_NORMAL;
			endcase
		end
	end
	assign cap_alarm_o = (cap_st == CAP_ACTIVE);

	// ==========================================================
	// Second and interval strobes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sec_div <= '0;
			sec_tick <= 1'b0;
			ivl_cnt <= '0;
			ivl_done_o <= 1'b0;
		end else begin
			sec_tick <= (sec_div == 27'(TICKS_PER_S - 1));
			sec_div <= (sec_div == 27'(TICKS_PER_S - 1)) ? '0 : sec_div + 27'h1;
			ivl_done_o <= sec_tick && (ivl_cnt == 10'(IVL_S - 1));
			if (sec_tick) begin
				ivl_cnt <= (ivl_cnt == 10'(IVL_S - 1)) ? '0 : ivl_cnt + 10'h1;
			end
		end
	end

	// ==========================================================
	// Alarms on current values
	// error ratio / received level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ber_exc_alarm_o <= 1'b0;
			ber_deg_alarm_o <= 1'b0;
			rsl_alarm_o <= 1'b0;
		end else begin
			ber_exc_alarm_o <= ber_i > ber_exc_thr;
			ber_deg_alarm_o <= ber_i > ber_deg_thr;
			rsl_alarm_o <= (sq_i[0] < rsl_alm_thr) || (sq_i[4] < rsl_alm_thr);
		end
	end

	// ==========================================================
	// Statistics channels
	// two received-level thresholds / utilization threshold
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			ch_val[c] = THR_ZERO;
			ch_ta[c] = THR_ZERO;
			ch_tb[c] = THR_NONE;
			ch_bb[c] = 1'b0;
		end
		for (int s = 0; s < 8; s++) begin
			ch_val[s] = sq_i[s];
		end
		for (int r = 0; r < 2; r++) begin
			ch_ta[r*4] = rsl_thr1;
			ch_tb[r*4] = rsl_thr2;
			ch_bb[r*4] = 1'b1;
			ch_tb[r*4+1] = tsl_hi;
			ch_tb[r*4+2] = mse_hi;
			ch_ta[r*4+3] = xpi_lo;
		end
		ch_val[CH_UTIL] = {9'h000, util_i};
		ch_val[CH_THRU] = thru_i;
		ch_val[CH_CAPY] = capy_i;
		ch_val[CH_FER] = fer_i;
		ch_tb[CH_UTIL] = {9'h000, util_thr};
		// zero threshold / zero threshold / frame errors
		ch_tb[CH_THRU] = THR_ZERO;
		ch_tb[CH_CAPY] = THR_ZERO;
		ch_tb[CH_FER] = THR_ZERO;
	end

	for (genvar g = 0; g < NCH; g++) begin : g_stat
		rls_stat #(.IVL_S(IVL_S)) u_stat (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.sec_tick_i(sec_tick),
			.ivl_tick_i(ivl_done_o),
			.val_i(ch_val[g]),
			.thr_a_i(ch_ta[g]),
			.thr_b_i(ch_tb[g]),
			.b_below_i(ch_bb[g]),
			.min_o(r_min[g]),
			.max_o(r_max[g]),
			.avg_o(r_avg[g]),
			.cnt_a_o(r_ca[g]),
			.cnt_b_o(r_cb[g])
		);
	end

	// ==========================================================
	// Register bus
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	assign wr_word = bmerge(rd_word, wb_dat_i, wb_sel_i);

	always_comb begin
		status = '0;
		status[ST_SINGLE] = single_carrier_o;
		status[ST_XOK] = cross_polar_canceller_ok_o;
		status[ST_XALM] = xpc_alarm_o;
		status[ST_COND +: 4] = cond;
		status[ST_TIMING] = (cap_st == CAP_TIMING);
		status[ST_CAPPED] = cap_alarm_o;
		status[ST_BER_EXC] = ber_exc_alarm_o;
		status[ST_BER_DEG] = ber_deg_alarm_o;
		status[ST_RSL] = rsl_alarm_o;
		status[ST_CARRIER +: 2] = pin_s[1:0];
	end

	always_comb begin
		rd_word = '0;
		case (wb_adr_i)
			A_CTRL: rd_word[CTRL_CAP_EN] = cap_en;
			A_PWR_MAX: rd_word[7:0] = pwr_max;
			A_CAP_LVL: rd_word[7:0] = cap_lvl;
			A_CAP_TMO: rd_word[15:0] = cap_tmo;
			A_FREQ: rd_word = {freq1, freq0};
			A_SCRIPT: rd_word = {14'h0000, hsb_en, script_xok, script1, script0};
			A_THR0: rd_word = {rsl_thr2, rsl_thr1};
			A_THR1: rd_word = {mse_hi, tsl_hi};
			A_THR2: rd_word = {9'h000, util_thr, xpi_lo};
			A_BER: rd_word = {ber_deg_thr, ber_exc_thr};
			A_RSL_ALM: rd_word[15:0] = rsl_alm_thr;
			A_STATUS: rd_word = status;
			A_TXLVL: rd_word[7:0] = tx_level_o;
			A_RES_SEL: rd_word[3:0] = res_sel;
			A_RES_MM: rd_word = (res_sel < 4'(NCH)) ? {r_max[res_sel], r_min[res_sel]} : '0;
			A_RES_AVG: rd_word[15:0] = (res_sel < 4'(NCH)) ? r_avg[res_sel] : '0;
			A_RES_CNT: rd_word = (res_sel < 4'(NCH)) ? {r_cb[res_sel], r_ca[res_sel]} : '0;
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_word : '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cap_en <= 1'b0;
			cap_cancel <= 1'b0;
			pwr_max <= R_PWR_MAX;
			cap_lvl <= R_CAP_LVL;
			cap_tmo <= R_CAP_TMO;
			{freq1, freq0} <= '0;
			{hsb_en, script_xok, script1, script0} <= '0;
			{rsl_thr2, rsl_thr1, mse_hi, tsl_hi} <= '0;
			{util_thr, xpi_lo, ber_deg_thr, ber_exc_thr} <= '0;
			rsl_alm_thr <= '0;
			res_sel <= '0;
		end else begin
			cap_cancel <= wb_wr && (wb_adr_i == A_CTRL) && wr_word[CTRL_CANCEL];
			if (wb_wr) begin
				case (wb_adr_i)
					A_CTRL: cap_en <= wr_word[CTRL_CAP_EN];
					A_PWR_MAX: pwr_max <= wr_word[7:0];
					A_CAP_LVL: cap_lvl <= wr_word[7:0];
					A_CAP_TMO: cap_tmo <= wr_word[15:0];
					A_FREQ: {freq1, freq0} <= wr_word;
					A_SCRIPT: {hsb_en, script_xok, script1, script0} <= wr_word[SCR_HSB:0];
					A_THR0: {rsl_thr2, rsl_thr1} <= wr_word;
					A_THR1: {mse_hi, tsl_hi} <= wr_word;
					A_THR2: begin
						xpi_lo <= wr_word[15:0];
						util_thr <= (wr_word[22:16] > UTIL_MAX) ? UTIL_MAX : wr_word[22:16];
					end
					A_BER: {ber_deg_thr, ber_exc_thr} <= wr_word;
					A_RSL_ALM: rsl_alm_thr <= wr_word[15:0];
					A_RES_SEL: res_sel <= wr_word[3:0];
					default: res_sel <= res_sel;
				endcase
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_expire;
		cap_st == CAP_TIMING && cap_en && !(tx_level_o < pwr_max) && sec_tick
			&& next_tmo >= cap_tmo && !(sw_evt && pin_s[P_PEER]);
	endsequence
	sequence s_capped;
		cap_alarm_o ##1 (tx_level_o <= cap_lvl);
	endsequence

	property p_recover;
		!both_up |=> single_carrier_o;
	endproperty
	a_recover: assert property (p_recover) else $error("no single state");
	property p_mute;
		single_carrier_o && !pin_s[0] |=> mute_req_o[0] && single_carrier_o;
	endproperty
	a_mute: assert property (p_mute) else $error("mute not asked");
	property p_readmit;
		single_carrier_o && both_up |=> !single_carrier_o && mute_req_o == 2'b00;
	endproperty
	a_readmit: assert property (p_readmit) else $error("carrier not readmitted");
	property p_cond;
		$fell(cond[2]) |=> xpc_alarm_o && xpc_cond_evt_o[2];
	endproperty
	a_cond: assert property (p_cond) else $error("condition not flagged");
	property p_max;
		up_evt && !dn_evt && tx_level_o == pwr_max && cap_st != CAP_ACTIVE
			|=> tx_level_o == $past(tx_level_o);
	endproperty
	a_max: assert property (p_max) else $error("power beyond maximum");
	property p_start;
		cap_st == CAP_NORMAL && cap_en && tx_level_o == pwr_max && !sw_evt
			|=> cap_st == CAP_TIMING;
	endproperty
	a_start: assert property (p_start) else $error("timer not started");
	property p_cap;
		s_expire |=> s_capped;
	endproperty
	a_cap: assert property (p_cap) else $error("cap not applied");
	property p_abort;
		cap_st == CAP_TIMING && tx_level_o < pwr_max && !sw_evt |=> cap_st == CAP_NORMAL;
	endproperty
	a_abort: assert property (p_abort) else $error("timer not cleared");
	property p_hold;
		cap_alarm_o && !cap_cancel |=> cap_alarm_o;
	endproperty
	a_hold: assert property (p_hold) else $error("cap state lost");
	property p_ber;
		ber_i > ber_exc_thr |=> ber_exc_alarm_o;
	endproperty
	a_ber: assert property (p_ber) else $error("error ratio alarm missing");
endmodule : rls_top

`default_nettype wire

// ---- rls_far.sv ----
/*
 * Far-end radio model: sends power step indications and obeys mute requests.
 * Assumes the bench drives fade_i on clk_i and resets it with rst_i.
 */
`timescale 1ns/1ps
`default_nettype none

module rls_far (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link side
	input wire logic fade_i,
	input wire logic [1:0] mute_req_i,
	output logic pwr_up_o,
	output logic pwr_dn_o,
	output logic [1:0] muted_o
);
	logic [1:0] ph;
	// power step indication
	// Steps are two cycles high and two low, twice the closest spacing the pin sync accepts.
	always_ff @(posedge clk_i) begin
		ph <= rst_i ? 2'h0 : ph + 2'h1;
		pwr_up_o <= !rst_i && fade_i && ph[1];
		pwr_dn_o <= !rst_i && !fade_i && ph[1];
	end
	always_ff @(posedge clk_i) begin
		muted_o <= rst_i ? 2'h0 : mute_req_i;
	end
endmodule : rls_far

`default_nettype wire

// ---- testbench.sv ----
/*
 * Self-checking bench for the radio link supervisor with a far-end model.
 * Assumes short counts: four cycles a second and three seconds an interval.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import rls_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fade = 1'b0;
	logic peer = 1'b0, sw = 1'b0;
	logic ack, up, dn, single, ok, alm, cap, exc, deg, received_signal_level, done;
	logic [1:0] car = 2'h3, mute, muted;
	logic [3:0] evt, evt_seen = 4'h0;
	logic [7:0] adr = 8'h00;
	logic signed [7:0] lvl;
	logic [31:0] wdat = 32'h0, dat_o, rd;
	logic [7:0][15:0] sq = {8{16'h0080}};
	logic [6:0] util = 7'h32;
	logic [15:0] thru = 16'h0010, ber = 16'h0064;
	int failures = 0, compares = 0, cyc_n = 0;

	initial forever #5 clk_i = ~clk_i;

	rls_top #(.TICKS_PER_S(4), .IVL_S(3)) u_rls_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .carrier_up_i(car),
		.far_pwr_up_i(up), .far_pwr_dn_i(dn), .peer_cap_i(peer), .switchover_i(sw),
		.sq_i(sq), .util_i(util), .thru_i(thru), .capy_i(16'h0020), .fer_i(16'h0001),
		.ber_i(ber), .mute_req_o(mute), .single_carrier_o(single), .cross_polar_canceller_ok_o(ok),
		.xpc_alarm_o(alm), .xpc_cond_evt_o(evt), .tx_level_o(lvl), .cap_alarm_o(cap),
		.ber_exc_alarm_o(exc), .ber_deg_alarm_o(deg), .rsl_alarm_o(received_signal_level), .ivl_done_o(done));

	rls_far u_rls_far (.clk_i(clk_i), .rst_i(rst_i), .fade_i(fade), .mute_req_i(mute),
		.pwr_up_o(up), .pwr_dn_o(dn), .muted_o(muted));

	// ==========================================================
	// Bus and check tasks
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic print_verdict();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	// A hang is cut short well beyond the few hundred cycles the tests need.
	always @(posedge clk_i) begin
		evt_seen <= rst_i ? 4'h0 : (evt_seen | evt);
		cyc_n++;
		if (cyc_n == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, A_CAP_TMO, 32'h0);
		chk(rd, 32'h0000003c);
		bus(1'b0, 8'hfc, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, A_SCRIPT, 32'h00010000);
		repeat (3) @(posedge clk_i);
		chk({ok, alm}, 32'h2);
		bus(1'b1, A_SCRIPT, 32'h00030100);
		repeat (3) @(posedge clk_i);
		chk({ok, alm, evt_seen}, 32'h1e);
		bus(1'b1, A_SCRIPT, 32'h00010000);
		$display("conditions test done");
		bus(1'b1, A_CTRL, 32'hfffffffc);
		car <= 2'h2;
		repeat (8) @(posedge clk_i);
		chk({single, mute, muted, ok}, 32'h2a);
		car <= 2'h3;
		repeat (8) @(posedge clk_i);
		chk({single, mute, ok}, 32'h1);
		$display("recovery test done");
		bus(1'b1, A_PWR_MAX, 32'h000000f8);
		fade <= 1'b1;
		repeat (60) @(posedge clk_i);
		chk({cap, lvl}, 32'h0f8);
		bus(1'b1, A_CAP_LVL, 32'h000000f7);
		bus(1'b1, A_CAP_TMO, 32'h00000002);
		bus(1'b1, A_CTRL, 32'h00000001);
		repeat (40) @(posedge clk_i);
		chk({cap, lvl}, 32'h1f7);
		fade <= 1'b0;
		bus(1'b1, A_CTRL, 32'h00000002);
		repeat (4) @(posedge clk_i);
		chk(cap, 32'h0);
		peer <= 1'b1;
		sw <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk(cap, 32'h1);
		bus(1'b1, A_CTRL, 32'h00000002);
		repeat (4) @(posedge clk_i);
		chk(cap, 32'h0);
		bus(1'b1, A_CAP_TMO, 32'h00000020);
		bus(1'b1, A_CTRL, 32'h00000001);
		fade <= 1'b1;
		repeat (40) @(posedge clk_i);
		bus(1'b0, A_STATUS, 32'h0);
		chk(rd[ST_TIMING], 32'h1);
		fade <= 1'b0;
		repeat (12) @(posedge clk_i);
		bus(1'b0, A_STATUS, 32'h0);
		chk(rd[ST_CAPPED:ST_TIMING], 32'h0);
		peer <= 1'b0;
		sw <= 1'b0;
		$display("power test done");
		bus(1'b1, A_BER, 32'h00c80032);
		bus(1'b1, A_RSL_ALM, 32'h00000100);
		repeat (3) @(posedge clk_i);
		chk({exc, deg, received_signal_level}, 32'h5);
		bus(1'b1, A_THR2, 32'h00280000);
		repeat (2) begin
			@(posedge clk_i);
			while (done !== 1'b1) @(posedge clk_i);
		end
		bus(1'b1, A_RES_SEL, 32'h8);
		bus(1'b0, A_RES_MM, 32'h0);
		chk(rd, 32'h00320032);
		bus(1'b0, A_RES_CNT, 32'h0);
		chk(rd, 32'h00030000);
		bus(1'b1, A_RES_SEL, 32'h9);
		bus(1'b0, A_RES_AVG, 32'h0);
		chk(rd, 32'h00000010);
		bus(1'b0, A_RES_CNT, 32'h0);
		chk(rd, 32'h00030000);
		bus(1'b1, A_RES_SEL, 32'ha);
		bus(1'b0, A_RES_MM, 32'h0);
		chk(rd, 32'h00200020);
		bus(1'b1, A_RES_SEL, 32'hb);
		bus(1'b0, A_RES_AVG, 32'h0);
		chk(rd, 32'h00000001);
		bus(1'b1, A_RES_SEL, 32'h0);
		bus(1'b0, A_RES_MM, 32'h0);
		chk(rd, 32'h00800080);
		$display("measures test done");
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
